// file: rtl/csr_pkg.sv
// Purpose: Constants and carrier types for the core special function register bank
// Assumes: Byte-wide special function register space, direct addressing 80H to FFH
// Notes:   Offsets, reset values and field positions live here only

`default_nettype none

package csr_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_STACK_TOP   = 8'h81;
	localparam logic [7:0] ADR_DP_LOW      = 8'h82;
	localparam logic [7:0] ADR_DP_HIGH     = 8'h83;
	localparam logic [7:0] ADR_POWER_CTRL  = 8'h87;
	localparam logic [7:0] ADR_SILICON_REV = 8'hC2;
	localparam logic [7:0] ADR_STATUS_WORD = 8'hD0;
	localparam logic [7:0] ADR_ARITH_MAIN  = 8'hE0;
	localparam logic [7:0] ADR_MULDIV_AUX  = 8'hF0;
	localparam logic [7:0] ADR_CAL_OFS_LOW = 8'hF1;
	localparam logic [7:0] ADR_CAL_OFS_HI  = 8'hF2;
	localparam logic [7:0] ADR_CAL_GAIN_LO = 8'hF3;
	localparam logic [7:0] ADR_CAL_GAIN_HI = 8'hF4;
	localparam logic [7:0] ADR_SERIAL_CTRL = 8'hF8;

	// ----------------------------------------------------------------
	// Reset values and unoccupied read value
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_STACK_TOP   = 8'h07;
	localparam logic [7:0] RST_ZERO        = 8'h00;
	localparam logic [7:0] RST_CAL_OFS_HI  = 8'h20;
	localparam logic [7:0] RST_SERIAL_CTRL = 8'h04;
	localparam logic [7:0] RD_UNOCCUPIED   = 8'h00;
	// Arbitrary revision value
	localparam logic [7:0] SILICON_REV_DEF = 8'h3C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int STAT_CARRY      = 7;
	localparam int STAT_HALF_CARRY = 6;
	localparam int STAT_USER_ZERO  = 5;
	localparam int STAT_BANK_HIGH  = 4;
	localparam int STAT_BANK_LOW   = 3;
	localparam int STAT_OVERFLOW   = 2;
	localparam int STAT_USER_ONE   = 1;
	localparam int STAT_PARITY     = 0;
	localparam int SPI_MASTER_BIT = 4;
	localparam int SPI_RATE0_BIT  = 0;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
	} csr_byte_req_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       wdata;
		logic       wr;
	} csr_bit_req_t;

	typedef struct packed {
		logic carry_out_flag;
		logic half_carry_flag;
		logic signed_result_error_flag;
	} csr_flags_t;

	typedef struct packed {
		logic uart_rate_doubler;
		logic serial_wake_interrupt_enable;
		logic ext0_wake_interrupt_enable;
		logic reserved;
		logic user_status_bit_high;
		logic user_status_bit_low;
		logic deep_sleep_enable;
		logic core_halt_enable;
	} csr_power_t;

endpackage : csr_pkg

`default_nettype wire

// file: rtl/csr_bank.sv
// Purpose: Core special function registers with byte and bit access
// Assumes: All inputs synchronous to ref_clk; reads answer one cycle later
// Notes:   Stack, data pointer, status word, power control and calibration bytes

`timescale 1ns/100ps
`default_nettype none

module csr_bank #(
	parameter logic [7:0] SILICON_REV = csr_pkg::SILICON_REV_DEF,
	parameter logic [7:0] CAL_OFS_LOW = csr_pkg::RST_ZERO,
	parameter logic [7:0] CAL_OFS_HI  = csr_pkg::RST_CAL_OFS_HI,
	parameter logic [7:0] CAL_GAIN_LO = csr_pkg::RST_ZERO,
	parameter logic [7:0] CAL_GAIN_HI = csr_pkg::RST_ZERO
) (
	input  wire logic                   ref_clk,
	input  wire logic                   reset,
	input  wire csr_pkg::csr_byte_req_t byte_req,
	output logic [7:0]                  byte_rdata,
	input  wire csr_pkg::csr_bit_req_t  bit_req,
	output logic                        bit_rdata,
	input  wire logic                   arith_we,
	input  wire logic [7:0]             arith_wdata,
	input  wire logic                   aux_we,
	input  wire logic [7:0]             aux_d,
	input  wire logic                   flags_we,
	input  wire csr_pkg::csr_flags_t    flags_d,
	input  wire logic                   push_en,
	input  wire logic [7:0]             push_data,
	input  wire logic                   pop_en,
	input  wire logic                   ptr_we,
	input  wire logic [15:0]            ptr_wdata,
	input  wire logic                   ptr_inc,
	input  wire logic                   slave_select_pin,
	output logic                        ram_wr_en,
	output logic [7:0]                  ram_wr_addr,
	output logic [7:0]                  ram_wr_data,
	output logic [7:0]                  stack_top_reg,
	output logic [15:0]                 data_pointer_word,
	output logic [7:0]                  arith_main_reg,
	output logic [7:0]                  multiply_divide_aux_reg,
	output logic [7:0]                  cpu_status_word,
	output logic [1:0]                  reg_bank_sel,
	output csr_pkg::csr_power_t         power_control_reg,
	output logic [7:0]                  serial_ctrl,
	output logic [31:0]                 adc_cal_coeffs
);
	import csr_pkg::*;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Byte write replaces, bit write patches one bit, else hold
	function automatic logic [7:0] merge_wr(
		input logic [7:0]    cur,
		input logic [7:0]    adr,
		input csr_byte_req_t br,
		input csr_bit_req_t  bt
	);
		logic [7:0] res;
		res = cur;
		if (br.wr && br.addr == adr) begin
			res = br.wdata;
		end
		if (bt.wr && {bt.addr[7:3], 3'h0} == adr && adr[2:0] == 3'h0) begin
			res[bt.addr[2:0]] = bt.wdata;
		end
		return res;
	endfunction : merge_wr

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0]  stk_q;
	logic [7:0]  stk_d;
	logic [7:0]  ptr_lo_q;
	logic [7:0]  ptr_lo_d;
	logic [7:0]  ptr_hi_q;
	logic [7:0]  ptr_hi_d;
	logic [7:0]  pwr_q;
	logic [7:0]  pwr_d;
	logic [7:1]  stat_q;
	logic [7:0]  stat_d;
	logic [7:0]  arith_q;
	logic [7:0]  arith_d;
	logic [7:0]  aux_q;
	logic [7:0]  aux_d_n;
	logic [7:0]  spi_q;
	logic [7:0]  spi_d;
	logic [7:0]  ofsl_q;
	logic [7:0]  ofsh_q;
	logic [7:0]  gainl_q;
	logic [7:0]  gainh_q;
	logic [7:0]  ofsl_d;
	logic [7:0]  ofsh_d;
	logic [7:0]  gainl_d;
	logic [7:0]  gainh_d;
	logic        ram_wr_en_q;
	logic [7:0]  ram_wr_addr_q;
	logic [7:0]  ram_wr_data_q;
	logic [7:0]  rdata_q;
	logic        rbit_q;

	// ----------------------------------------------------------------
	// Derived wires
	// ----------------------------------------------------------------
	wire logic             parity_w;
	wire logic [7:0]       stat_full;
	wire logic [7:0]       spi_view;
	wire logic [7:0]       stk_next;
	wire logic [7:0]       stk_prev;
	wire logic [15:0]      ptr_word;
	wire logic [15:0]      ptr_plus;
	wire logic [7:0]       bit_byte_adr;
	wire logic [12:0][7:0] rd_regs;
	wire logic [7:0]       rd_mux;
	wire logic [7:0]       bit_src;
	wire logic             bit_val;

	assign parity_w  = ^arith_q;
	assign stat_full = {stat_q, parity_w};

	// Rate bit zero shows slave select pin while the master bit is clear
	assign spi_view = spi_q[SPI_MASTER_BIT] ? spi_q
		: {spi_q[7:1], slave_select_pin};

	assign stk_next = stk_q + 8'h01;
	assign stk_prev = stk_q - 8'h01;

	assign ptr_word = {ptr_hi_q, ptr_lo_q};
	assign ptr_plus = ptr_word + 16'h0001;

	assign bit_byte_adr = {bit_req.addr[7:3], 3'h0};

	// ----------------------------------------------------------------
	// Read sources
	// ----------------------------------------------------------------
	// Sources go in as an argument so reads follow every state change
	assign rd_regs[0]  = stk_q;
	assign rd_regs[1]  = ptr_lo_q;
	assign rd_regs[2]  = ptr_hi_q;
	assign rd_regs[3]  = pwr_q;
	assign rd_regs[4]  = SILICON_REV;
	assign rd_regs[5]  = stat_full;
	assign rd_regs[6]  = arith_q;
	assign rd_regs[7]  = aux_q;
	assign rd_regs[8]  = ofsl_q;
	assign rd_regs[9]  = ofsh_q;
	assign rd_regs[10] = gainl_q;
	assign rd_regs[11] = gainh_q;
	assign rd_regs[12] = spi_view;

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	// Unoccupied offsets read a fixed value; reserved bits read back as stored
	function automatic logic [7:0] read_sel(
		input logic [7:0]       adr,
		input logic [12:0][7:0] regs
	);
		logic [7:0] r;
		r = RD_UNOCCUPIED;
		case (adr)
			ADR_STACK_TOP:   r = regs[0];
			ADR_DP_LOW:      r = regs[1];
			ADR_DP_HIGH:     r = regs[2];
			ADR_POWER_CTRL:  r = regs[3];
			ADR_SILICON_REV: r = regs[4];
			ADR_STATUS_WORD: r = regs[5];
			ADR_ARITH_MAIN:  r = regs[6];
			ADR_MULDIV_AUX:  r = regs[7];
			ADR_CAL_OFS_LOW: r = regs[8];
			ADR_CAL_OFS_HI:  r = regs[9];
			ADR_CAL_GAIN_LO: r = regs[10];
			ADR_CAL_GAIN_HI: r = regs[11];
			ADR_SERIAL_CTRL: r = regs[12];
			default:         r = RD_UNOCCUPIED;
		endcase
		return r;
	endfunction : read_sel

	assign rd_mux  = read_sel(byte_req.addr, rd_regs);
	assign bit_src = read_sel(bit_byte_adr, rd_regs);
	assign bit_val = bit_src[bit_req.addr[2:0]];

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Byte and bit writes update only decoded offsets; core strobes also update storage
	always_comb begin
		stk_d = stk_q;
		if (push_en) begin
			stk_d = stk_next;
		end else if (pop_en) begin
			stk_d = stk_prev;
		end
		stk_d = merge_wr(stk_d, ADR_STACK_TOP, byte_req, bit_req);

		// Word load, increment, or byte access
		ptr_lo_d = ptr_lo_q;
		ptr_hi_d = ptr_hi_q;
		if (ptr_we) begin
			ptr_hi_d = ptr_wdata[15:8];
			ptr_lo_d = ptr_wdata[7:0];
		end else if (ptr_inc) begin
			ptr_hi_d = ptr_plus[15:8];
			ptr_lo_d = ptr_plus[7:0];
		end
		ptr_lo_d = merge_wr(ptr_lo_d, ADR_DP_LOW, byte_req, bit_req);
		ptr_hi_d = merge_wr(ptr_hi_d, ADR_DP_HIGH, byte_req, bit_req);

		pwr_d = merge_wr(pwr_q, ADR_POWER_CTRL, byte_req, bit_req);

		// Core flag updates, then direct writes
		stat_d = stat_full;
		if (flags_we) begin
			stat_d[STAT_CARRY]      = flags_d.carry_out_flag;
			stat_d[STAT_HALF_CARRY] = flags_d.half_carry_flag;
			stat_d[STAT_OVERFLOW]   = flags_d.signed_result_error_flag;
		end
		stat_d = merge_wr(stat_d, ADR_STATUS_WORD, byte_req, bit_req);

		arith_d = arith_we ? arith_wdata : arith_q;
		arith_d = merge_wr(arith_d, ADR_ARITH_MAIN, byte_req, bit_req);

		aux_d_n = aux_we ? aux_d : aux_q;
		aux_d_n = merge_wr(aux_d_n, ADR_MULDIV_AUX, byte_req, bit_req);

		spi_d = merge_wr(spi_q, ADR_SERIAL_CTRL, byte_req, bit_req);

		ofsl_d  = merge_wr(ofsl_q, ADR_CAL_OFS_LOW, byte_req, bit_req);
		ofsh_d  = merge_wr(ofsh_q, ADR_CAL_OFS_HI, byte_req, bit_req);
		gainl_d = merge_wr(gainl_q, ADR_CAL_GAIN_LO, byte_req, bit_req);
		gainh_d = merge_wr(gainh_q, ADR_CAL_GAIN_HI, byte_req, bit_req);
	end

	// ----------------------------------------------------------------
	// Register update
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			stk_q    <= RST_STACK_TOP;
			ptr_lo_q <= RST_ZERO;
			ptr_hi_q <= RST_ZERO;
			pwr_q    <= RST_ZERO;
			stat_q   <= RST_ZERO[7:1];
			arith_q  <= RST_ZERO;
			aux_q   <= RST_ZERO;
			spi_q   <= RST_SERIAL_CTRL;
			ofsl_q  <= CAL_OFS_LOW;
			ofsh_q  <= CAL_OFS_HI;
			gainl_q <= CAL_GAIN_LO;
			gainh_q <= CAL_GAIN_HI;
		end else begin
			stk_q    <= stk_d;
			ptr_lo_q <= ptr_lo_d;
			ptr_hi_q <= ptr_hi_d;
			pwr_q    <= pwr_d;
			stat_q   <= stat_d[7:1];
			arith_q  <= arith_d;
			aux_q   <= aux_d_n;
			spi_q   <= spi_d;
			ofsl_q  <= ofsl_d;
			ofsh_q  <= ofsh_d;
			gainl_q <= gainl_d;
			gainh_q <= gainh_d;
		end
	end

	// RAM write at the incremented address
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ram_wr_en_q   <= 1'b0;
			ram_wr_addr_q <= RST_ZERO;
			ram_wr_data_q <= RST_ZERO;
		end else begin
			ram_wr_en_q   <= push_en;
			ram_wr_addr_q <= push_en ? stk_next : ram_wr_addr_q;
			ram_wr_data_q <= push_en ? push_data : ram_wr_data_q;
		end
	end

	// Read data registered, one cycle after request
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata_q <= RST_ZERO;
			rbit_q  <= 1'b0;
		end else begin
			rdata_q <= rd_mux;
			rbit_q  <= bit_val;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign byte_rdata              = rdata_q;
	assign bit_rdata               = rbit_q;
	assign ram_wr_en               = ram_wr_en_q;
	assign ram_wr_addr             = ram_wr_addr_q;
	assign ram_wr_data             = ram_wr_data_q;
	assign stack_top_reg           = stk_q;
	assign data_pointer_word       = ptr_word;
	assign arith_main_reg          = arith_q;
	assign multiply_divide_aux_reg = aux_q;
	assign cpu_status_word         = stat_full;
	assign reg_bank_sel            = {stat_q[STAT_BANK_HIGH], stat_q[STAT_BANK_LOW]};
	assign power_control_reg       = pwr_q;
	assign serial_ctrl             = spi_q;
	assign adc_cal_coeffs          = {gainh_q, gainl_q, ofsh_q, ofsl_q};

endmodule : csr_bank

`default_nettype wire

// file: verification/csr_bank_assertions.sv
// Purpose: Port checks for csr_bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Read data lags its address by one cycle
`timescale 1ns/100ps
`default_nettype none
module csr_bank_assertions #(
	parameter logic [7:0] SILICON_REV = csr_pkg::SILICON_REV_DEF
) (
	input wire logic                   ref_clk,
	input wire logic                   reset,
	input wire csr_pkg::csr_byte_req_t byte_req,
	input wire logic [7:0]             byte_rdata,
	input wire csr_pkg::csr_bit_req_t  bit_req,
	input wire logic                   bit_rdata,
	input wire logic                   push_en,
	input wire logic [7:0]             push_data,
	input wire logic                   slave_select_pin,
	input wire logic                   ram_wr_en,
	input wire logic [7:0]             ram_wr_addr,
	input wire logic [7:0]             ram_wr_data,
	input wire logic [7:0]             stack_top_reg,
	input wire logic [15:0]            data_pointer_word,
	input wire logic [7:0]             cpu_status_word,
	input wire logic [1:0]             reg_bank_sel,
	input wire logic [7:0]             serial_ctrl
);
	import csr_pkg::*;
	wire stk_wr = byte_req.wr && byte_req.addr == ADR_STACK_TOP;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	// ------
	// Checks
	// ------
	AST_PUSH_INC: // push raises top
		assert property (push_en && !stk_wr |=> stack_top_reg == $past(stack_top_reg) + 8'h01)
		else $error("push did not raise stack top");
	AST_PUSH_RAM: // store at new top
		assert property (push_en && !stk_wr |=> ram_wr_en && ram_wr_addr == stack_top_reg && ram_wr_data == $past(push_data))
		else $error("push store wrong");
	AST_RAM_QUIET: // no stray stores
		assert property (!push_en |=> !ram_wr_en)
		else $error("store without push");
	AST_RST_VAL: // reset values
		assert property (disable iff (1'b0) reset |=> stack_top_reg == RST_STACK_TOP && data_pointer_word == 16'h0000
			&& cpu_status_word == RST_ZERO)
		else $error("reset values wrong");
	AST_SP_READ: // stack at 81H
		assert property (byte_req.addr == ADR_STACK_TOP |=> byte_rdata == $past(stack_top_reg))
		else $error("stack top read wrong");
	AST_REV_RO: // fixed revision byte
		assert property (byte_req.addr == ADR_SILICON_REV |=> byte_rdata == SILICON_REV)
		else $error("revision read wrong");
	AST_BANK: // bank select bits
		assert property (reg_bank_sel == cpu_status_word[STAT_BANK_HIGH:STAT_BANK_LOW])
		else $error("bank select mismatch");
	AST_RATE_PIN: // pin replaces bit
		assert property (bit_req.addr == ADR_SERIAL_CTRL && !serial_ctrl[SPI_MASTER_BIT]
			|=> bit_rdata == $past(slave_select_pin))
		else $error("rate bit not pin");
	COV_PUSH2: cover property (push_en [*2]);
	COV_PSW_BIT: cover property (bit_req.wr && bit_req.addr[7:3] == 5'h1A);
	COV_BANK3: cover property (reg_bank_sel == 2'h3);
endmodule : csr_bank_assertions
`default_nettype wire

// file: verification/csr_ram_model.sv
// Purpose: Internal data RAM behind stack stores
// Assumes: Stores arrive as one-cycle strobes
// Notes:   Counts stores so the bench sees extras
`timescale 1ns/100ps
`default_nettype none
module csr_ram_model (
	input wire logic       ref_clk,
	input wire logic       ram_wr_en,
	input wire logic [7:0] ram_wr_addr,
	input wire logic [7:0] ram_wr_data
);
	logic [7:0]  mem [256];
	logic [15:0] wr_count = 16'h0000;
	always @(posedge ref_clk) begin
		if (ram_wr_en) begin
			mem[ram_wr_addr] <= ram_wr_data;
			wr_count <= wr_count + 16'h0001;
		end
	end
endmodule : csr_ram_model
`default_nettype wire

// file: verification/tb_csr_bank.sv
// Purpose: Self-checking bench for csr_bank
// Assumes: Inputs change 1 ns after each rising edge
// Notes:   Expectations come from a shadow map
`timescale 1ns/100ps
`default_nettype none
module tb_csr_bank;
	import csr_pkg::*;
	// Arbitrary revision value
	localparam logic [7:0] REV = 8'h5A;
	logic          ref_clk = 1'b0;
	logic          reset = 1'b1;
	csr_byte_req_t byte_req = '0;
	csr_bit_req_t  bit_req = '0;
	csr_flags_t    flags_d = '0;
	logic          arith_we = 0, aux_we = 0, flags_we = 0, push_en = 0, pop_en = 0;
	logic          ptr_we = 0, ptr_inc = 0, slave_select_pin = 0;
	logic [7:0]    arith_wdata = 0, aux_d = 0, push_data = 0;
	logic [15:0]   ptr_wdata = 0, data_pointer_word;
	logic [31:0]   adc_cal_coeffs;
	logic [7:0]    byte_rdata, ram_wr_addr, ram_wr_data, stack_top_reg, arith_main_reg;
	logic [7:0]    multiply_divide_aux_reg, cpu_status_word, serial_ctrl, a, d, push_log [3], sh [256];
	logic [1:0]    reg_bank_sel;
	logic          bit_rdata, ram_wr_en;
	csr_power_t    power_control_reg;
	int            mismatches = 0;
	int            checked = 0;
	logic [7:0] map [15] = '{8'h81, 8'h82, 8'h83, 8'h87, 8'hC2, 8'hD0, 8'hE0, 8'hF0,
		8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF8, 8'h80, 8'hC4};
	logic [7:0] bba [4] = '{8'hD0, 8'hE0, 8'hF0, 8'hF8};
	csr_bank #(.SILICON_REV(REV)) u_csr_bank (.ref_clk, .reset, .byte_req, .byte_rdata, .bit_req, .bit_rdata,
		.arith_we, .arith_wdata, .aux_we, .aux_d, .flags_we, .flags_d, .push_en, .push_data, .pop_en, .ptr_we,
		.ptr_wdata, .ptr_inc, .slave_select_pin, .ram_wr_en, .ram_wr_addr, .ram_wr_data, .stack_top_reg,
		.data_pointer_word, .arith_main_reg, .multiply_divide_aux_reg, .cpu_status_word, .reg_bank_sel,
		.power_control_reg, .serial_ctrl, .adc_cal_coeffs);
	csr_ram_model u_csr_ram_model (.ref_clk, .ram_wr_en, .ram_wr_addr, .ram_wr_data);
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	function automatic logic [7:0] exp_rd(logic [7:0] x);
		case (x)
			ADR_STATUS_WORD: return {sh[x][7:1], ^sh[ADR_ARITH_MAIN]};
			ADR_SILICON_REV: return REV;
			8'h80, 8'hC4: return RD_UNOCCUPIED;
			ADR_SERIAL_CTRL: return sh[x][SPI_MASTER_BIT] ? sh[x] : {sh[x][7:1], slave_select_pin};
			default: return sh[x];
		endcase
	endfunction : exp_rd
	task automatic cyc;
		@(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(logic [7:0] x, logic [7:0] v);
		byte_req = '{x, v, 1'b1};
		if (x != ADR_SILICON_REV && x != 8'h80 && x != 8'hC4)
			sh[x] = v;
		cyc;
	endtask : wr
	task automatic rc(logic [7:0] x);
		byte_req = '{x, 8'h00, 1'b0};
		cyc;
		chk("byte_rdata", {8'h00, exp_rd(x)}, {8'h00, byte_rdata});
	endtask : rc
	task automatic bt(logic [7:0] x, logic w, logic v);
		bit_req = '{x, v, w};
		cyc;
	endtask : bt
	task automatic sweep;
		foreach (map[i])
			rc(map[i]);
	endtask : sweep
	task automatic conclude;
		$display("Comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	initial begin
		#100000;
		mismatches++;
		conclude;
	end
	initial begin
		void'($urandom(32'h8CC9B365));
		foreach (sh[i])
			sh[i] = RST_ZERO;
		sh[ADR_STACK_TOP] = RST_STACK_TOP;
		sh[ADR_CAL_OFS_HI] = RST_CAL_OFS_HI;
		sh[ADR_SERIAL_CTRL] = RST_SERIAL_CTRL;
		repeat (4) cyc;
		reset = 1'b0;
		sweep;
		chk("cal low", {sh[ADR_CAL_OFS_HI], sh[ADR_CAL_OFS_LOW]}, adc_cal_coeffs[15:0]);
		chk("cal high", {sh[ADR_CAL_GAIN_HI], sh[ADR_CAL_GAIN_LO]}, adc_cal_coeffs[31:16]);
		// Back-to-back pushes, then one pop
		push_en = 1'b1;
		foreach (push_log[i]) begin
			push_data = 8'($urandom);
			push_log[i] = push_data;
			cyc;
		end
		push_en = 1'b0;
		pop_en = 1'b1;
		cyc;
		pop_en = 1'b0;
		sh[ADR_STACK_TOP] = RST_STACK_TOP + 8'h02;
		chk("stack_top_reg", {8'h00, sh[ADR_STACK_TOP]}, {8'h00, stack_top_reg});
		foreach (push_log[i])
			chk("ram byte", {8'h00, push_log[i]}, {8'h00, u_csr_ram_model.mem[8 + i]});
		chk("ram writes", 16'h0003, u_csr_ram_model.wr_count);
		// Push wraps from the top of RAM
		wr(ADR_STACK_TOP, 8'hFF);
		byte_req.wr = 1'b0;
		push_en = 1'b1;
		push_data = 8'($urandom);
		cyc;
		push_en = 1'b0;
		cyc;
		sh[ADR_STACK_TOP] = 8'h00;
		chk("ram wrap", {8'h00, push_data}, {8'h00, u_csr_ram_model.mem[0]});
		repeat (40) begin
			a = map[$urandom_range(14)];
			d = 8'($urandom);
			slave_select_pin = 1'($urandom);
			wr(a, a == ADR_POWER_CTRL ? d & 8'hEF : d);
			rc(a);
		end
		sweep;
		chk("data_pointer_word", {sh[ADR_DP_HIGH], sh[ADR_DP_LOW]}, data_pointer_word);
		chk("power_control_reg", {8'h00, sh[ADR_POWER_CTRL]}, {8'h00, power_control_reg});
		for (int k = 0; k < 4; k++) begin
			wr(ADR_STATUS_WORD, 8'(k << STAT_BANK_LOW));
			chk("reg_bank_sel", 16'(k), {14'h0000, reg_bank_sel});
		end
		rc(ADR_STATUS_WORD);
		foreach (bba[i]) begin
			a = bba[i] | 8'(1 + $urandom_range(6));
			d[0] = 1'($urandom);
			bt(a, 1'b1, d[0]);
			sh[bba[i]][a[2:0]] = d[0];
			bt(a, 1'b0, 1'b0);
			chk("bit_rdata", {15'h0000, d[0]}, {15'h0000, bit_rdata});
			rc(bba[i]);
		end
		wr(ADR_SERIAL_CTRL, 8'h00);
		repeat (4) begin
			slave_select_pin = ~slave_select_pin;
			bt(ADR_SERIAL_CTRL, 1'b0, 1'b0);
			chk("rate bit", {15'h0000, slave_select_pin}, {15'h0000, bit_rdata});
		end
		slave_select_pin = 1'b1;
		wr(ADR_SERIAL_CTRL, 8'h10);
		bt(ADR_SERIAL_CTRL, 1'b0, 1'b0);
		chk("rate bit", 16'h0000, {15'h0000, bit_rdata});
		rc(ADR_SERIAL_CTRL);
		// Core strobes, pointer wraps on increment
		{arith_we, aux_we, flags_we, ptr_we} = 4'hF;
		arith_wdata = 8'($urandom);
		aux_d = 8'($urandom);
		flags_d = 3'($urandom);
		ptr_wdata = 16'hFFFF;
		cyc;
		{arith_we, aux_we, flags_we, ptr_we, ptr_inc} = 5'h01;
		cyc;
		ptr_inc = 1'b0;
		sh[ADR_ARITH_MAIN] = arith_wdata;
		sh[ADR_MULDIV_AUX] = aux_d;
		{sh[ADR_STATUS_WORD][STAT_CARRY], sh[ADR_STATUS_WORD][STAT_HALF_CARRY], sh[ADR_STATUS_WORD][STAT_OVERFLOW]} = flags_d;
		sh[ADR_DP_LOW] = 8'h00;
		sh[ADR_DP_HIGH] = 8'h00;
		sweep;
		chk("arith_main_reg", {8'h00, sh[ADR_ARITH_MAIN]}, {8'h00, arith_main_reg});
		chk("multiply_divide_aux_reg", {8'h00, sh[ADR_MULDIV_AUX]}, {8'h00, multiply_divide_aux_reg});
		chk("cpu_status_word", {8'h00, exp_rd(ADR_STATUS_WORD)}, {8'h00, cpu_status_word});
		chk("serial_ctrl", {8'h00, sh[ADR_SERIAL_CTRL]}, {8'h00, serial_ctrl});
		chk("cal low", {sh[ADR_CAL_OFS_HI], sh[ADR_CAL_OFS_LOW]}, adc_cal_coeffs[15:0]);
		chk("cal high", {sh[ADR_CAL_GAIN_HI], sh[ADR_CAL_GAIN_LO]}, adc_cal_coeffs[31:16]);
		conclude;
	end
endmodule : tb_csr_bank
bind csr_bank csr_bank_assertions #(.SILICON_REV(SILICON_REV)) u_csr_bank_assertions (.ref_clk, .reset,
	.byte_req, .byte_rdata, .bit_req, .bit_rdata, .push_en, .push_data, .slave_select_pin, .ram_wr_en,
	.ram_wr_addr, .ram_wr_data, .stack_top_reg, .data_pointer_word, .cpu_status_word, .reg_bank_sel, .serial_ctrl);
`default_nettype wire
